// ---- verilog/pilot_pwm_decoder.sv ----
// top of the charging_station pilot logic; adc samples arrive synchronous to mclk
`timescale 1ns/1ns
`default_nettype none
module pilot_pwm_decoder #(
   parameter int PERIOD_CYCLES = pilot_pkg::PERIOD_CYCLES,
   parameter logic [6:0] RATED = pilot_pkg::RATED_AMPS,
   parameter int DEB = pilot_pkg::DEBOUNCE_PERIODS
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic derate_en,
   input wire logic [pilot_pkg::AMPS_W-1:0] derate_amps,
   input wire logic sample_valid,
   input wire logic [pilot_pkg::ADC_W-1:0] sample_code,
   output logic pilot_drive,
   output logic relay_close,
   output logic fault,
   output logic [2:0] pilot_state,
   output logic state_change
);
   import pilot_pkg::*;

   localparam int PW = $clog2(PERIOD_CYCLES + 1);
   localparam int XW = PW + 10;

   initial begin
      if (DEB < 2 || DEB > 7) $error("pilot_pwm_decoder: DEB must be 2..7");
      if (PERIOD_CYCLES < 2) $error("pilot_pwm_decoder: PERIOD_CYCLES too small");
      if (RATED < MIN_AMPS || RATED > MAX_AMPS) $error("pilot_pwm_decoder: RATED out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // current setting and compare value

   wire [6:0] req_amps = (derate_en && derate_amps < RATED) ? derate_amps : RATED;
   wire [6:0] eff_amps = (req_amps < MIN_AMPS) ? MIN_AMPS :
                         (req_amps > MAX_AMPS) ? MAX_AMPS : req_amps;
   wire [XW-1:0] per_x = XW'(PERIOD_CYCLES);
   wire [XW-1:0] num_lo = per_x * XW'(eff_amps);
   wire [XW-1:0] num_hi = per_x * (XW'(DUTY_HI_MUL) * XW'(eff_amps) + XW'(DUTY_HI_OFS));
   wire [XW-1:0] cmp_lo = num_lo / XW'(DUTY_LO_DIV);
   wire [XW-1:0] cmp_hi = num_hi / XW'(DUTY_HI_DIV);
   wire [PW-1:0] compare = (eff_amps <= BAND_SPLIT_AMPS) ? cmp_lo[PW-1:0] : cmp_hi[PW-1:0];

   ////////////////////////////////////////////////////////////////////////
   // timer channel

   ctl_state_e ctl_reg;
   ctl_state_e ctl_next;
   logic period_end;
   // pwm keeps running in fault so the diode check can see the vehicle leave
   wire pwm_en = (ctl_reg != CS_IDLE);

   pilot_pwm_timer #(.PERIOD(PERIOD_CYCLES), .PW(PW)) u_timer (
      .mclk(mclk),
      .reset(reset),
      .ce(ce),
      .enable(pwm_en),
      .compare(compare),
      .drive(pilot_drive),
      .period_end(period_end)
   );

   ////////////////////////////////////////////////////////////////////////
   // per-period peak and trough of the sampled pilot

   logic [9:0] hi_reg;
   logic [9:0] lo_reg;
   logic seen_reg;
   logic chk_reg;
   wire take = ce & sample_valid;
   wire [9:0] hi_upd = (take && (!seen_reg || sample_code > hi_reg)) ? sample_code : hi_reg;
   wire [9:0] lo_upd = (take && (!seen_reg || sample_code < lo_reg)) ? sample_code : lo_reg;
   wire seen_upd = seen_reg | take;

   always_ff @(posedge mclk) begin
      if (reset) begin
         hi_reg <= '0;
         lo_reg <= '0;
         seen_reg <= 1'b0;
         chk_reg <= 1'b0;
      end else if (period_end) begin
         hi_reg <= '0;
         lo_reg <= '0;
         seen_reg <= 1'b0;
         // leaving for idle stops the pwm, so the next period has no low half to check
         chk_reg <= pwm_en & (ctl_next != CS_IDLE);
      end else if (ce) begin
         hi_reg <= hi_upd;
         lo_reg <= lo_upd;
         seen_reg <= seen_upd;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // level classification, closing sample included

   // a pwm-driven line that never reaches -10.5 V means no vehicle diode
   wire diode_bad = chk_reg & (lo_upd > TH_NEG);
   wire [2:0] cls = !seen_upd ? 3'(PS_F) :
                    (hi_upd >= TH_A) ? 3'(PS_A) :
                    diode_bad && hi_upd >= TH_D ? 3'(PS_E) :
                    (hi_upd >= TH_B) ? 3'(PS_B) :
                    (hi_upd >= TH_C) ? 3'(PS_C) :
                    (hi_upd >= TH_D) ? 3'(PS_D) :
                    (hi_upd >= TH_E) ? 3'(PS_E) : 3'(PS_F);

   ////////////////////////////////////////////////////////////////////////
   // debounce

   logic [2:0] cand_reg;
   logic [2:0] run_reg;
   logic [2:0] state_reg;
   logic change_reg;
   wire same = (cls == cand_reg);
   wire adopt = period_end & same & (run_reg == 3'(DEB - 2)) & (cls != state_reg);

   always_ff @(posedge mclk) begin
      if (reset) begin
         cand_reg <= 3'(PS_A);
         run_reg <= '0;
         state_reg <= 3'(PS_A);
         change_reg <= 1'b0;
      end else if (ce) begin
         change_reg <= adopt;
         if (period_end) begin
            cand_reg <= cls;
            run_reg <= !same ? 3'h0 : (run_reg == 3'(DEB - 1)) ? run_reg : run_reg + 3'h1;
         end
         if (adopt) begin
            state_reg <= cls;
         end
      end
   end

   assign pilot_state = state_reg;
   assign state_change = change_reg;

   ////////////////////////////////////////////////////////////////////////
   // connection control

   wire to_err = (cls == 3'(PS_E)) || (cls == 3'(PS_F));
   wire to_chg = (cls == 3'(PS_C)) || (cls == 3'(PS_D));

   always_comb begin
      ctl_next = ctl_reg;
      if (adopt) begin
         unique case (ctl_reg)
            CS_IDLE: begin
               if (to_err) ctl_next = CS_FAULT;
               else if (cls == 3'(PS_B)) ctl_next = CS_READY;
               else if (to_chg) ctl_next = CS_CHARGE;
            end
            CS_READY: begin
               if (to_err) ctl_next = CS_FAULT;
               else if (cls == 3'(PS_A)) ctl_next = CS_IDLE;
               else if (to_chg) ctl_next = CS_CHARGE;
            end
            CS_CHARGE: begin
               if (to_err) ctl_next = CS_FAULT;
               else if (cls == 3'(PS_A)) ctl_next = CS_IDLE;
               else if (cls == 3'(PS_B)) ctl_next = CS_READY;
            end
            CS_FAULT: begin
               if (cls == 3'(PS_A)) ctl_next = CS_IDLE;
            end
            default: ctl_next = CS_FAULT;
         endcase
      end
   end

   logic relay_reg;
   logic fault_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         ctl_reg <= CS_IDLE;
         relay_reg <= 1'b0;
         fault_reg <= 1'b0;
      end else if (ce) begin
         ctl_reg <= ctl_next;
         relay_reg <= (ctl_next == CS_READY) || (ctl_next == CS_CHARGE);
         fault_reg <= (ctl_next == CS_FAULT);
      end
   end

   assign relay_close = relay_reg;
   assign fault = fault_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_duty_low: assert property (@(posedge mclk) disable iff (reset)
      eff_amps <= BAND_SPLIT_AMPS |-> XW'(compare) * XW'(DUTY_LO_DIV) <= num_lo
      && XW'(compare) * XW'(DUTY_LO_DIV) + XW'(DUTY_LO_DIV) > num_lo)
      else $error("low band compare wrong");
   a_duty_high: assert property (@(posedge mclk) disable iff (reset)
      eff_amps > BAND_SPLIT_AMPS |-> XW'(compare) * XW'(DUTY_HI_DIV) <= num_hi
      && XW'(compare) * XW'(DUTY_HI_DIV) + XW'(DUTY_HI_DIV) > num_hi)
      else $error("high band compare wrong");
   a_amps_range: assert property (@(posedge mclk) disable iff (reset)
      eff_amps >= MIN_AMPS && eff_amps <= MAX_AMPS && eff_amps <= RATED)
      else $error("advertised current out of range");
   a_derate_use: assert property (@(posedge mclk) disable iff (reset)
      derate_en && derate_amps >= MIN_AMPS && derate_amps < RATED |-> eff_amps == derate_amps)
      else $error("derate request ignored");
   a_peak_track: assert property (@(posedge mclk) disable iff (reset)
      take && !period_end && seen_reg && sample_code > hi_reg |=> hi_reg == $past(sample_code))
      else $error("pilot peak not tracked");
   a_no_sample_f: assert property (@(posedge mclk) disable iff (reset)
      !seen_reg && !take |-> cls == 3'(PS_F))
      else $error("silent period not decoded as F");
   a_vent_level: assert property (@(posedge mclk) disable iff (reset)
      seen_upd && hi_upd >= TH_D && hi_upd < TH_C && !diode_bad |-> cls == 3'(PS_D))
      else $error("3 V level not decoded as D");
   a_debounce_run: assert property (@(posedge mclk) disable iff (reset)
      ce && change_reg && $past(ce) |-> $past(run_reg) == 3'(DEB - 2) && $past(period_end))
      else $error("state changed before debounce");
   a_ready_relay: assert property (@(posedge mclk) disable iff (reset)
      ce && adopt && ctl_reg == CS_IDLE && cls == 3'(PS_B) |=> relay_reg && pwm_en)
      else $error("ready level did not close relays");
   a_fault_open: assert property (@(posedge mclk) disable iff (reset)
      ce && adopt && to_err |=> !relay_reg && fault_reg)
      else $error("fault did not remove power");
endmodule
`default_nettype wire

// ---- verilog/pilot_pkg.sv ----
// constants shared by the pilot pwm decoder, the vehicle model and the bench
// assumes a 100 MHz mclk and a 10-bit adc spanning -12 V..+12 V linearly
package pilot_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PWM_PERIOD_US = 1000;
   localparam int PERIOD_CYCLES = PWM_PERIOD_US * 1000 / CLK_PERIOD_NS;

   localparam int AMPS_W = 7;
   localparam int ADC_W = 10;
   localparam logic [6:0] MIN_AMPS = 7'h06;
   localparam logic [6:0] MAX_AMPS = 7'h50;
   localparam logic [6:0] BAND_SPLIT_AMPS = 7'h33;
   localparam logic [6:0] RATED_AMPS = 7'h1E;
   // duty = amps/0.6 % -> fraction amps/60
   localparam int DUTY_LO_DIV = 60;
   // duty = amps/2.5 + 64 % -> fraction (2*amps + 320)/500
   localparam int DUTY_HI_MUL = 2;
   localparam int DUTY_HI_OFS = 320;
   localparam int DUTY_HI_DIV = 500;

   // adc codes of band edges: +11, +7.5, +4, +0.5, -3, -10.5 V
   localparam logic [9:0] TH_A = 10'h3D4;
   localparam logic [9:0] TH_B = 10'h33F;
   localparam logic [9:0] TH_C = 10'h2AA;
   localparam logic [9:0] TH_D = 10'h215;
   localparam logic [9:0] TH_E = 10'h180;
   localparam logic [9:0] TH_NEG = 10'h040;

   localparam int DEBOUNCE_PERIODS = 4;

   typedef enum logic [2:0] {
      PS_A = 3'h0,
      PS_B = 3'h1,
      PS_C = 3'h2,
      PS_D = 3'h3,
      PS_E = 3'h4,
      PS_F = 3'h5
   } pilot_state_e;

   typedef enum logic [3:0] {
      CS_IDLE = 4'h1,
      CS_READY = 4'h2,
      CS_CHARGE = 4'h4,
      CS_FAULT = 4'h8
   } ctl_state_e;
endpackage

// ---- verilog/pilot_pwm_timer.sv ----
// hardware timer channel: free-running period counter with one compare
// assumes compare never exceeds the period; compare is taken at period start
`timescale 1ns/1ns
`default_nettype none
module pilot_pwm_timer #(
   parameter int PERIOD = 100000,
   parameter int PW = 17
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic ce,
   input wire logic enable,
   input wire logic [PW-1:0] compare,
   output logic drive,
   output logic period_end
);
   initial begin
      if (PERIOD < 2 || PERIOD >= (1 << PW)) $error("pilot_pwm_timer: PERIOD does not fit PW");
   end

   logic [PW-1:0] cnt_reg;
   logic [PW-1:0] cmp_reg;
   logic drive_reg;
   wire at_end = (cnt_reg == PW'(PERIOD - 1));
   wire [PW-1:0] cnt_next = at_end ? '0 : cnt_reg + PW'(1);
   wire [PW-1:0] cmp_use = at_end ? compare : cmp_reg;

   assign period_end = ce & at_end;
   assign drive = drive_reg;

   // disabled channel holds the line at the positive level
   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_reg <= '0;
         cmp_reg <= '0;
         drive_reg <= 1'b1;
      end else if (ce) begin
         cnt_reg <= cnt_next;
         cmp_reg <= cmp_use;
         drive_reg <= ~enable | (cnt_next < cmp_use);
      end
   end

   a_period_wrap: assert property (@(posedge mclk) disable iff (reset) ce && at_end |=> cnt_reg == '0)
      else $error("period counter did not wrap");
   a_idle_level: assert property (@(posedge mclk) disable iff (reset) ce && !enable |=> drive_reg)
      else $error("disabled pilot not held high");
   a_duty_edge: assert property (@(posedge mclk) disable iff (reset)
      ce && enable && !at_end && cnt_reg >= cmp_reg |=> !drive_reg)
      else $error("pilot still high past the compare point");
endmodule
`default_nettype wire

// ---- testbench/ev_vehicle_model.sv ----
// vehicle end of the pilot wire: a resistor load picked by the bench
// assumes the 10-bit adc scale, 0 = -12 V and 3FF = +12 V
`timescale 1ns/1ns
`default_nettype none
module ev_vehicle_model (
   input wire logic mclk,
   input wire logic pilot_drive,
   input wire logic [2:0] load_state,
   input wire logic mute,
   output logic sample_valid,
   output logic [9:0] sample_code
);
   import pilot_pkg::*;
   logic [9:0] hi_code;
   logic [9:0] lo_code;
   ////////////////////////////////////////////////////////////////////////
   // the load pulls the high half down; the diode leaves -12 V alone except in PS_E and load 3'h6
   always_comb begin
      lo_code = 10'h000;
      case (load_state)
         PS_A: hi_code = 10'h3FF;
         PS_B: hi_code = 10'h380;
         PS_C: hi_code = 10'h2FF;
         PS_D: hi_code = 10'h27F;
         PS_E: begin
            hi_code = 10'h1FF;
            lo_code = 10'h1FF;
         end
         // ready load with its diode missing: the low half is pulled up too
         3'h6: begin
            hi_code = 10'h380;
            lo_code = 10'h080;
         end
         default: hi_code = 10'h000;
      endcase
   end
   // the load never follows the advertised duty: no extra draw to see
   assign sample_valid = ~mute;
   always_ff @(posedge mclk) begin
      sample_code <= pilot_drive ? hi_code : lo_code;
   end
endmodule
`default_nettype wire

// ---- testbench/ev_pilot_pwm_state_decoder_tb_top.sv ----
// bench for the pilot pwm and state decoder, short period and debounce
// assumes the vehicle model answers every cycle with an adc sample unless mute is set
`timescale 1ns/1ns
`default_nettype none
module ev_pilot_pwm_state_decoder_tb_top;
   import pilot_pkg::*;
   localparam int P = 100;
   typedef struct {logic [2:0] load; logic [2:0] st; logic relay; logic flt;} row_s;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic derate_en = 1'b0;
   logic mute = 1'b0;
   logic [6:0] derate_amps = 7'h00;
   logic [2:0] load_state = PS_A;
   logic sample_valid, pilot_drive, relay_close, fault, state_change;
   logic [9:0] sample_code;
   logic [2:0] pilot_state;
   logic [2:0] last_st;
   logic [15:0] hi;
   int n_errors = 0;
   int num_checks = 0;
   int n_pulse = 0;
   int p0;
   row_s rows[10] = '{'{PS_B, 3'h1, 1'b1, 1'b0}, '{PS_C, 3'h2, 1'b1, 1'b0}, '{PS_D, 3'h3, 1'b1, 1'b0},
      '{PS_B, 3'h1, 1'b1, 1'b0}, '{PS_A, 3'h0, 1'b0, 1'b0}, '{PS_C, 3'h2, 1'b1, 1'b0},
      '{PS_F, 3'h5, 1'b0, 1'b1}, '{PS_A, 3'h0, 1'b0, 1'b0}, '{PS_E, 3'h4, 1'b0, 1'b1},
      '{PS_A, 3'h0, 1'b0, 1'b0}};
   logic [6:0] amps[7] = '{7'h50, 7'h41, 7'h33, 7'h1E, 7'h0F, 7'h03, 7'h60};
   logic [15:0] duty[7] = '{16'h0060, 16'h005A, 16'h0055, 16'h0032, 16'h0019, 16'h000A, 16'h0060};

   always #5 mclk = ~mclk;
   always @(posedge mclk) if (state_change === 1'b1) n_pulse++;

   pilot_pwm_decoder #(.PERIOD_CYCLES(P), .RATED(7'h50), .DEB(2)) pilot_pwm_decoder_i (
      .mclk(mclk), .reset(reset), .ce(ce), .derate_en(derate_en), .derate_amps(derate_amps),
      .sample_valid(sample_valid), .sample_code(sample_code), .pilot_drive(pilot_drive),
      .relay_close(relay_close), .fault(fault), .pilot_state(pilot_state),
      .state_change(state_change));
   ev_vehicle_model ev_vehicle_model_i (.mclk(mclk), .pilot_drive(pilot_drive),
      .load_state(load_state), .mute(mute), .sample_valid(sample_valid), .sample_code(sample_code));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t %s got=%h exp=%h", $time, what, got, exp);
      end
   endtask

   // counts high cycles over a full period; any alignment gives the compare
   task automatic count_high();
      hi = 16'h0000;
      repeat (P) begin
         @(negedge mclk);
         hi = hi + {15'h0000, pilot_drive};
      end
   endtask

   task automatic settle(input logic [2:0] ld, input int periods);
      @(posedge mclk) load_state <= ld;
      repeat (periods * P) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic check_outs(input logic [2:0] st, input logic relay, input logic flt);
      check("state", {13'h0000, pilot_state}, {13'h0000, st});
      check("relay", {15'h0000, relay_close}, {15'h0000, relay});
      check("fault", {15'h0000, fault}, {15'h0000, flt});
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      check_outs(PS_A, 1'b0, 1'b0);
      count_high();
      check("idle dc", hi, 16'h0064);
      last_st = PS_A;
      foreach (rows[i]) begin
         p0 = n_pulse;
         settle(rows[i].load, 4);
         check_outs(rows[i].st, rows[i].relay, rows[i].flt);
         check("pulse", 16'(n_pulse - p0), {15'h0000, rows[i].st !== last_st});
         last_st = rows[i].st;
      end
      settle(PS_B, 4);
      count_high();
      check("rated", hi, 16'h0060);
      foreach (amps[i]) begin
         @(posedge mclk) derate_en <= 1'b1;
         derate_amps <= amps[i];
         repeat (3 * P) @(posedge mclk);
         count_high();
         check("duty", hi, duty[i]);
      end
      // a one-period glitch must not be adopted
      p0 = n_pulse;
      settle(PS_C, 1);
      settle(PS_B, 4);
      check_outs(PS_B, 1'b1, 1'b0);
      check("glitch", 16'(n_pulse - p0), 16'h0000);
      @(posedge mclk) ce <= 1'b0;
      settle(PS_A, 4);
      check_outs(PS_B, 1'b1, 1'b0);
      @(posedge mclk) ce <= 1'b1;
      settle(PS_A, 4);
      check_outs(PS_A, 1'b0, 1'b0);
      // a silent adc leaves nothing to classify
      @(posedge mclk) mute <= 1'b1;
      settle(PS_A, 4);
      check_outs(PS_F, 1'b0, 1'b1);
      @(posedge mclk) mute <= 1'b0;
      settle(PS_A, 4);
      check_outs(PS_A, 1'b0, 1'b0);
      settle(PS_C, 4);
      check_outs(PS_C, 1'b1, 1'b0);
      // vehicle diode missing while charging
      settle(3'h6, 4);
      check_outs(PS_E, 1'b0, 1'b1);
      @(posedge mclk) reset <= 1'b1;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(negedge mclk);
      check_outs(PS_A, 1'b0, 1'b0);
      check("drive", {15'h0000, pilot_drive}, 16'h0001);
      tally_and_finish();
   end
endmodule
`default_nettype wire
